// [emwb_core.v]
// Command side of the graphics DRAM: extended mode load and write break by read.
//
// Notes on behaviour
// R1 - Extended load: all strobes low, bank0 high.
// R2 - Register undefined until controller writes it.
// R3 - Capture address and bank1 on command edge.
// R4 - Address bits 1 and 6 pick strength.
// R5 - Controller waits two cycles after load.
// R6 - Reload allowed only while banks idle.
// R7 - Address bit 0 enables the DLL.
// R8 - Unused address and bank inputs held low.
// R9 - Read to any bank breaks write burst.
// R10 - Controller floats data one cycle early.
// R11 - Controller masks residual words around read.
// R12 - Controller keeps last write to read gap.
// R13 - Unmasked words before read are stored.
// R14 - Read at least two cycles after write.
// R15 - Controller releases data and strobe early.
// R16 - Strobe edges of discarded words ignored.
// R17 - Write break only at low clock rates.
// R18 - Last write to read gap two cycles.
// R19 - DLL needs 200 cycles after enable.
// R20 - Unused strength code selects normal strength.
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "emwb_map.vh"
module emwb_core #(
  parameter DATA_W = 16,
  parameter ADDR_W = 13,
  parameter DEPTH = 16,
  parameter IDX_W = 4
) (
  // Clock and reset.
  input wire clk,
  input wire resetn,
  // APB slave.
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Memory pins from the controller, all asynchronous to clk.
  input wire memClk,
  input wire clockGate,
  input wire chipSelectN,
  input wire rowStrobeN,
  input wire columnStrobeN,
  input wire writeStrobeN,
  input wire [1:0] bankSel,
  input wire [ADDR_W-1:0] addrLines,
  input wire [DATA_W-1:0] dataLines,
  input wire [DATA_W/8-1:0] byteWriteMask,
  input wire dataStrobe,
  // Mode and event outputs.
  output reg dllEnable,
  output reg [1:0] driveStrength,
  output reg readAccepted,
  output reg writeBroken
);
  localparam MASK_W = DATA_W / 8;
  localparam SYNC_W = 6 + 2 + ADDR_W + MASK_W + 1 + DATA_W;

  // Synchronised pin levels.
  wire sClk, sCke, sCsN, sRasN, sCasN, sWeN, sStrobe;
  wire [1:0] sBank;
  wire [ADDR_W-1:0] sAddr;
  wire [MASK_W-1:0] sMask;
  wire [DATA_W-1:0] sData;
  wire [SYNC_W-1:0] syncBus;

  // All pins cross together so command, address and data stay aligned.
  emwb_sync #(.W(SYNC_W)) pinSync (
    .clk(clk),
    .resetn(resetn),
    .asyncIn({memClk, clockGate, chipSelectN, rowStrobeN, columnStrobeN, writeStrobeN,
              bankSel, addrLines, byteWriteMask, dataStrobe, dataLines}),
    .syncOut(syncBus)
  );
  assign {sClk, sCke, sCsN, sRasN, sCasN, sWeN, sBank, sAddr, sMask, sStrobe, sData} = syncBus;

  // State registers.
  reg memClkPrev_reg; // Previous link clock level, for edge detection.
  reg strobePrev_reg; // Previous strobe level; both edges carry data.
  reg [7:0] ctrl_reg; // Write-break enable and burst length in words.
  reg [ADDR_W:0] extRaw_reg; // Last captured address with bank1 on top.
  reg extLoaded_reg; // Set once a load has been taken since reset.
  reg [1:0] busy_reg; // Link cycles left for the load to complete.
  reg [3:0] bankActive_reg; // One bit per open bank.
  reg writeActive_reg; // A burst write is taking words.
  reg discard_reg; // Remaining words of a broken burst are dropped.
  reg [3:0] wordCnt_reg; // Words seen in the current burst.
  reg [IDX_W-1:0] col_reg; // Starting column of the burst.
  reg [1:0] sinceWr_reg; // Link cycles since the last write command, saturating.
  reg [2:0] err_reg; // Sticky error flags, write one to clear.
  reg [7:0] stored_reg; // Count of words written into the array.
  reg [7:0] dropped_reg; // Count of strobe edges ignored after a break.
  reg [IDX_W-1:0] idx_reg; // Array index for software readout.

  // Decoded events on the link clock rising edge and on either data strobe edge.
  wire memRise = sClk & ~memClkPrev_reg;
  wire strobeEdge = sStrobe ^ strobePrev_reg;
  wire cmdValid = memRise & sCke & ~sCsN;
  wire cmdExt = cmdValid & ~sRasN & ~sCasN & ~sWeN & sBank[0]; // [R1]
  wire cmdAct = cmdValid & ~sRasN & sCasN & sWeN;
  wire cmdPre = cmdValid & ~sRasN & sCasN & ~sWeN;
  wire cmdWr = cmdValid & sRasN & ~sCasN & ~sWeN;
  wire cmdRd = cmdValid & sRasN & ~sCasN & sWeN;
  wire allIdle = (bankActive_reg == 4'h0);
  wire [3:0] burstWords = ctrl_reg[`EMWB_CTRL_BURST_MSB:`EMWB_CTRL_BURST_LSB];
  wire wirOn = ctrl_reg[`EMWB_CTRL_WIR_BIT];
  wire wordHit = strobeEdge & writeActive_reg;
  wire wordLast = ((wordCnt_reg + 4'h1) == burstWords);
  wire [IDX_W-1:0] wrIdx = col_reg + wordCnt_reg[IDX_W-1:0];
  wire breakReq = cmdRd & writeActive_reg;

  // APB phases: one wait state, the write lands on the completing edge.
  wire apbAccess = psel & penable & ~pready;
  wire apbDone = psel & penable & pready;
  wire apbWrite = apbDone & pwrite;

  // Strength field; the spare code falls back to normal drive.
  reg [1:0] strengthNext;
  always @* begin
    case ({sAddr[`EMWB_A_DRV_HI], sAddr[`EMWB_A_DRV_LO]}) // [R4]
      2'h0: strengthNext = `EMWB_DRV_NORMAL;
      2'h1: strengthNext = `EMWB_DRV_WEAK;
      2'h2: strengthNext = `EMWB_DRV_MATCHED;
      default: strengthNext = `EMWB_DRV_NORMAL; // [R20]
    endcase
  end

  // Array storage: one flop byte per entry and lane, masked lanes keep old data.
  wire [DEPTH*DATA_W-1:0] arrayFlat;
  genvar e, b;
  generate
    for (e = 0; e < DEPTH; e = e + 1) begin : gEntry
      for (b = 0; b < MASK_W; b = b + 1) begin : gLane
        reg [7:0] cell_reg;
        // Words arriving before the breaking read, even in its own cycle, are kept.
        always @(posedge clk or negedge resetn) begin
          if (!resetn) begin
            cell_reg <= 8'h00;
          end else if (wordHit && (wrIdx == e) && !sMask[b]) begin
            cell_reg <= sData[b*8 +: 8]; // [R13]
          end
        end
        assign arrayFlat[e*DATA_W + b*8 +: 8] = cell_reg;
      end
    end
  endgenerate

  // Register read mux and address decode.
  reg [31:0] readMux;
  reg addrHit;
  always @* begin
    readMux = 32'h0000_0000;
    addrHit = 1'b1;
    case (paddr)
      `EMWB_OFF_CTRL: readMux = {24'h00_0000, ctrl_reg};
      `EMWB_OFF_STATUS: readMux = {22'h00_0000, extLoaded_reg, bankActive_reg, writeActive_reg,
                                   (busy_reg != 2'h0), driveStrength, dllEnable};
      `EMWB_OFF_EXTRAW: readMux = {{(31 - ADDR_W){1'b0}}, extRaw_reg};
      `EMWB_OFF_ERROR: readMux = {29'h0000_0000, err_reg};
      `EMWB_OFF_ARRIDX: readMux = {{(32 - IDX_W){1'b0}}, idx_reg};
      `EMWB_OFF_ARRDATA: readMux = {{(32 - DATA_W){1'b0}}, arrayFlat[idx_reg*DATA_W +: DATA_W]};
      `EMWB_OFF_COUNTS: readMux = {16'h0000, dropped_reg, stored_reg};
      default: addrHit = 1'b0;
    endcase
  end

  // Error flags: a new event beats a software clear in the same cycle.
  wire [2:0] errSet;
  assign errSet[`EMWB_ERR_NOT_IDLE] = cmdExt & ~allIdle;
  assign errSet[`EMWB_ERR_TOO_SOON] = breakReq & (sinceWr_reg < (`EMWB_MIN_WR_TO_RD - 2'h1)); // [R14]
  assign errSet[`EMWB_ERR_WIR_OFF] = breakReq & ~wirOn;
  wire [2:0] errClr = (apbWrite && paddr == `EMWB_OFF_ERROR) ? pwdata[2:0] : 3'h0;

  // APB slave handshake and software-written registers.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      ctrl_reg <= `EMWB_CTRL_RESET;
      idx_reg <= {IDX_W{1'b0}};
      err_reg <= 3'h0;
    end else begin
      if (apbAccess) begin
        pready <= 1'b1;
        pslverr <= ~addrHit;
        prdata <= readMux;
      end else begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h0000_0000;
      end
      if (apbWrite && paddr == `EMWB_OFF_CTRL) begin
        ctrl_reg <= pwdata[7:0];
      end
      if (apbWrite && paddr == `EMWB_OFF_ARRIDX) begin
        idx_reg <= pwdata[IDX_W-1:0];
      end
      err_reg <= (err_reg & ~errClr) | errSet;
    end
  end

  // Link-side command engine: mode load, bank tracking and write bursts.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      memClkPrev_reg <= 1'b0;
      strobePrev_reg <= 1'b0;
      extRaw_reg <= {(ADDR_W + 1){1'b0}};
      extLoaded_reg <= 1'b0;
      dllEnable <= 1'b0;
      driveStrength <= `EMWB_DRV_NORMAL;
      busy_reg <= 2'h0;
      bankActive_reg <= 4'h0;
      writeActive_reg <= 1'b0;
      discard_reg <= 1'b0;
      wordCnt_reg <= 4'h0;
      col_reg <= {IDX_W{1'b0}};
      sinceWr_reg <= `EMWB_SINCE_SAT;
      stored_reg <= 8'h00;
      dropped_reg <= 8'h00;
      readAccepted <= 1'b0;
      writeBroken <= 1'b0;
    end else begin
      memClkPrev_reg <= sClk;
      strobePrev_reg <= sStrobe;
      readAccepted <= 1'b0;
      writeBroken <= 1'b0;
      // Load completion counts down on link edges.
      if (memRise && busy_reg != 2'h0) begin
        busy_reg <= busy_reg - 2'h1;
      end
      if (memRise && sinceWr_reg != `EMWB_SINCE_SAT) begin
        sinceWr_reg <= sinceWr_reg + 2'h1;
      end
      // Mode load is taken only with every bank precharged; otherwise it is flagged and dropped.
      if (cmdExt && allIdle) begin // [R1]
        extRaw_reg <= {sBank[1], sAddr}; // [R3]
        dllEnable <= sAddr[`EMWB_A_DLL]; // [R7]
        driveStrength <= strengthNext; // [R4]
        extLoaded_reg <= 1'b1;
        busy_reg <= `EMWB_EXT_LOAD_CYCLES;
      end
      // Bank open and close tracking gates the mode load.
      if (cmdAct) begin
        bankActive_reg[sBank] <= 1'b1;
      end
      if (cmdPre) begin
        if (sAddr[`EMWB_A_ALL_BANKS]) begin
          bankActive_reg <= 4'h0;
        end else begin
          bankActive_reg[sBank] <= 1'b0;
        end
      end
      // Word counting; a data word in the break cycle still counts as stored.
      if (wordHit) begin
        if (sMask != {MASK_W{1'b1}}) begin
          stored_reg <= stored_reg + 8'h01;
        end
        if (wordLast) begin
          writeActive_reg <= 1'b0;
        end else begin
          wordCnt_reg <= wordCnt_reg + 4'h1;
        end
      end
      // Strobe edges of dropped words touch only the drop and word counters and the discard flag.
      if (strobeEdge && discard_reg) begin // [R16]
        dropped_reg <= dropped_reg + 8'h01;
        if (wordLast) begin
          discard_reg <= 1'b0;
        end else begin
          wordCnt_reg <= wordCnt_reg + 4'h1;
        end
      end
      // A read breaks the burst only when software allows the low-rate feature.
      if (cmdRd) begin
        if (!writeActive_reg) begin
          readAccepted <= 1'b1;
        end else if (wirOn) begin // [R17]
          writeActive_reg <= 1'b0; // [R9]
          discard_reg <= ~wordLast | ~wordHit;
          writeBroken <= 1'b1;
          readAccepted <= 1'b1;
        end
      end
      // A new write command starts a fresh burst and ends any discard.
      if (cmdWr) begin
        writeActive_reg <= 1'b1;
        discard_reg <= 1'b0;
        wordCnt_reg <= 4'h0;
        col_reg <= sAddr[IDX_W-1:0];
        sinceWr_reg <= 2'h0;
      end
    end
  end
endmodule // emwb_core
`default_nettype wire

// [emwb_core_properties.sv]
// Port-level assertions for the command block: bus timing, mode loads and write break.
`timescale 1ns/10ps
`default_nettype none
module emwb_core_properties #(
  parameter ADDR_W = 13
) (
  // Clock and reset.
  input wire clk,
  input wire resetn,
  // Register bus.
  input wire psel,
  input wire penable,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Command pins.
  input wire chipSelectN,
  input wire rowStrobeN,
  input wire columnStrobeN,
  input wire writeStrobeN,
  input wire [1:0] bankSel,
  input wire [ADDR_W-1:0] addrLines,
  // Mode and event outputs.
  input wire dllEnable,
  input wire [1:0] driveStrength,
  input wire readAccepted,
  input wire writeBroken
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // The load code on the pins; a mode output may only move four cycles after it is seen.
  wire loadPins = !chipSelectN && !rowStrobeN && !columnStrobeN && !writeStrobeN && bankSel[0];
  a_ready_one_wait:
    assert property (psel && penable && !pready |=> pready) else $error("no answer after one wait cycle");
  a_ready_single:
    assert property (pready |=> !pready) else $error("ready held too long");
  a_ready_in_access:
    assert property (pready |-> psel && penable && $past(penable)) else $error("ready outside access");
  a_idle_data_zero:
    assert property (!pready |-> prdata == 32'h0000_0000) else $error("read data outside answer");
  a_error_zero_data:
    assert property (pslverr |-> pready && prdata == 32'h0000_0000) else $error("bad error answer");
  a_mode_from_load:
    assert property ($changed(dllEnable) || $changed(driveStrength) |-> $past(loadPins, 4))
    else $error("mode changed without a load");
  a_dll_from_addr:
    assert property ($changed(dllEnable) |-> dllEnable == $past(addrLines[0], 4))
    else $error("dll level not from address bit");
  a_strength_code:
    assert property ($changed(driveStrength) |-> driveStrength ==
      {$past(addrLines[6] & ~addrLines[1], 4), $past(addrLines[1] & ~addrLines[6], 4)})
    else $error("wrong drive strength");
  a_break_with_read:
    assert property (writeBroken |-> readAccepted ##1 !readAccepted [*8]) else $error("break without read");
  // Main scenarios reached.
  c_break: cover property (writeBroken);
  c_refused: cover property (pready && pslverr);
  c_strength: cover property ($changed(driveStrength));
endmodule // emwb_core_properties
`default_nettype wire

// [emwb_core_tb.sv]
// Self-checking bench: mode loads, a refused load and a write broken by a read.
`timescale 1ns/10ps
`default_nettype none
`include "emwb_map.vh"
`define EMWB_CHK(w, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected %s expected %h seen %h", w, e, g); end end
module emwb_core_tb;
  // Clock, reset and bus master.
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  wire [31:0] prdata;
  wire pready, pslverr;
  // Controller pins and mode outputs.
  wire memClk, clockGate, chipSelectN, rowStrobeN, columnStrobeN, writeStrobeN, dataStrobe;
  wire [1:0] bankSel, byteWriteMask, driveStrength;
  wire [12:0] addrLines;
  wire [15:0] dataLines;
  wire dllEnable, readAccepted, writeBroken;
  // Notes {read, error, data}, counters and random state.
  logic [33:0] expQ[$];
  int err_count = 0;
  int n_tests = 0;
  int nBreak = 0;
  int nRead = 0;
  logic [31:0] rs = 32'h0000_4c4f;
  logic [12:0] a;
  logic [15:0] d0;
  always #2.5 clk = ~clk;
  emwb_core i_emwb_core (.clk(clk), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .memClk(memClk), .clockGate(clockGate), .chipSelectN(chipSelectN), .rowStrobeN(rowStrobeN),
    .columnStrobeN(columnStrobeN), .writeStrobeN(writeStrobeN), .bankSel(bankSel), .addrLines(addrLines),
    .dataLines(dataLines), .byteWriteMask(byteWriteMask), .dataStrobe(dataStrobe), .dllEnable(dllEnable),
    .driveStrength(driveStrength), .readAccepted(readAccepted), .writeBroken(writeBroken));
  emwb_ctl_model i_emwb_ctl_model (.memClk(memClk), .clockGate(clockGate), .chipSelectN(chipSelectN),
    .rowStrobeN(rowStrobeN), .columnStrobeN(columnStrobeN), .writeStrobeN(writeStrobeN), .bankSel(bankSel),
    .addrLines(addrLines), .dataLines(dataLines), .byteWriteMask(byteWriteMask), .dataStrobe(dataStrobe));
  // Xorshift step for data and the dll bit.
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // One bus transfer; the note is queued first, the request held until ready is sampled.
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd, input logic [32:0] ex);
    int k;
    expQ.push_back({!wr, ex});
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      err_count++;
      tally_and_finish();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Monitor: every answer takes the oldest note; writes check only the error flag.
  always @(posedge clk) begin : mon
    logic [33:0] e;
    if (pready === 1'b1) begin
      e = expQ.pop_front();
      `EMWB_CHK("slave error", e[32], pslverr)
      if (e[33]) `EMWB_CHK("read data", e[31:0], prdata)
    end
    if (writeBroken === 1'b1)
      nBreak++;
    if (readAccepted === 1'b1)
      nRead++;
  end
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    apb(0, `EMWB_OFF_CTRL, 0, {1'b0, 32'h0000_0041});
    // Every strength code, random dll bit, two idle cycles after each load.
    for (int i = 0; i < 4; i++) begin
      rs = xs(rs);
      a = {6'h00, i[1], 4'h0, i[0], rs[0]};
      i_emwb_ctl_model.cmd(4'b0000, 2'b01, a);
      repeat (2) i_emwb_ctl_model.cmd(4'b0111, 2'b00, 13'h0000);
      apb(0, `EMWB_OFF_STATUS, 0, {1'b0, 22'h0, 1'b1, 6'h00, (i == 3) ? 2'h0 : i[1:0], rs[0]});
      apb(0, `EMWB_OFF_EXTRAW, 0, {20'h0, a});
    end
    // The DLL gets its lock time before any link read is relied upon.
    repeat (200) i_emwb_ctl_model.cmd(4'b0111, 2'b00, 13'h0000);
    // A load with a bank open is dropped and flagged, then the flag is cleared.
    i_emwb_ctl_model.cmd(4'b0011, 2'b00, 13'h0011);
    i_emwb_ctl_model.cmd(4'b0000, 2'b01, {12'h000, ~rs[0]});
    apb(0, `EMWB_OFF_ERROR, 0, {1'b0, 32'h0000_0001});
    apb(0, `EMWB_OFF_STATUS, 0, {1'b0, 22'h0, 1'b1, 4'h1, 4'h0, rs[0]});
    apb(1, `EMWB_OFF_ERROR, 32'h0000_0007, {1'b0, 32'h0000_0000});
    // Write, one kept and one masked word, gap, read, then a word that must be dropped.
    d0 = rs[31:16];
    i_emwb_ctl_model.cmd(4'b0100, 2'b00, 13'h0000);
    i_emwb_ctl_model.word(d0, 2'b00);
    i_emwb_ctl_model.word(~d0, 2'b11);
    // Three idle cycles let the write distance counter saturate before the read.
    repeat (3) i_emwb_ctl_model.cmd(4'b0111, 2'b00, 13'h0000);
    i_emwb_ctl_model.cmd(4'b0101, 2'b00, 13'h0000);
    i_emwb_ctl_model.word(d0 ^ 16'h5a5a, 2'b11);
    `EMWB_CHK("break pulses", 1, nBreak)
    apb(1, `EMWB_OFF_ARRIDX, 0, {1'b0, 32'h0000_0000});
    apb(0, `EMWB_OFF_ARRDATA, 0, {1'b0, 16'h0000, d0});
    apb(0, `EMWB_OFF_COUNTS, 0, {1'b0, 32'h0000_0101});
    apb(0, `EMWB_OFF_ERROR, 0, {1'b0, 32'h0000_0000});
    // A read one cycle after a write is flagged and still breaks the burst.
    i_emwb_ctl_model.cmd(4'b0100, 2'b00, 13'h0004);
    i_emwb_ctl_model.cmd(4'b0101, 2'b00, 13'h0000);
    apb(0, `EMWB_OFF_ERROR, 0, {1'b0, 32'h0000_0002});
    // With the break disabled a read during a write is ignored, flagged, and the write goes on.
    apb(1, `EMWB_OFF_CTRL, 32'h0000_0040, {1'b0, 32'h0000_0000});
    i_emwb_ctl_model.cmd(4'b0100, 2'b00, 13'h0008);
    repeat (2) i_emwb_ctl_model.cmd(4'b0111, 2'b00, 13'h0000);
    i_emwb_ctl_model.cmd(4'b0101, 2'b00, 13'h0000);
    apb(0, `EMWB_OFF_ERROR, 0, {1'b0, 32'h0000_0006});
    apb(0, `EMWB_OFF_STATUS, 0, {1'b0, 22'h0, 1'b1, 4'h1, 1'b1, 3'h0, rs[0]});
    `EMWB_CHK("break pulses", 2, nBreak)
    `EMWB_CHK("read pulses", 2, nRead)
    apb(0, 8'h1C, 0, {1'b1, 32'h0000_0000});
    tally_and_finish();
  end
  // Watchdog against a hang anywhere.
  initial begin
    #100000;
    err_count++;
    tally_and_finish();
  end
endmodule // emwb_core_tb
bind emwb_core emwb_core_properties #(.ADDR_W(ADDR_W)) i_props (.clk(clk), .resetn(resetn), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .chipSelectN(chipSelectN),
  .rowStrobeN(rowStrobeN), .columnStrobeN(columnStrobeN), .writeStrobeN(writeStrobeN), .bankSel(bankSel),
  .addrLines(addrLines), .dllEnable(dllEnable), .driveStrength(driveStrength), .readAccepted(readAccepted),
  .writeBroken(writeBroken));
`default_nettype wire

// [emwb_ctl_model.sv]
// Behavioural memory controller driving command, address and write data pins.
`timescale 1ns/10ps
`default_nettype none
module emwb_ctl_model (
  // Link clock and gate.
  output var logic memClk,
  output var logic clockGate,
  // Command strobes, active low.
  output var logic chipSelectN,
  output var logic rowStrobeN,
  output var logic columnStrobeN,
  output var logic writeStrobeN,
  // Bank and address.
  output var logic [1:0] bankSel,
  output var logic [12:0] addrLines,
  // Write data side.
  output var logic [15:0] dataLines,
  output var logic [1:0] byteWriteMask,
  output var logic dataStrobe
);
  // Idle pins: deselected, gate high, link clock parked low.
  initial begin
    {memClk, chipSelectN, rowStrobeN, columnStrobeN, writeStrobeN} = 5'h0f;
    clockGate = 1'b1;
    bankSel = 2'h0;
    addrLines = 13'h0000;
    dataLines = 16'h0000;
    byteWriteMask = 2'h3;
    dataStrobe = 1'b0;
  end
  // One link cycle with code {cs, ras, cas, we}; pins settle well before the rising edge.
  // The link clock stands still between calls, so spacing is counted in calls.
  task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a);
    {chipSelectN, rowStrobeN, columnStrobeN, writeStrobeN} = c;
    bankSel = b;
    addrLines = a;
    #31.25 memClk = 1'b1;
    #62.5 memClk = 1'b0;
    #31.25;
  endtask
  // One word per strobe edge; after the hold the lines no longer show the old value.
  task automatic word(input logic [15:0] d, input logic [1:0] m);
    dataLines = d;
    byteWriteMask = m;
    #20 dataStrobe = ~dataStrobe;
    #20 dataLines = ~d;
  endtask
endmodule // emwb_ctl_model
`default_nettype wire

// [emwb_map.vh]
// Shared constants: register offsets, field positions, reset values and timing counts.
`ifndef EMWB_MAP_VH
`define EMWB_MAP_VH

// Register byte offsets on the APB side.
`define EMWB_OFF_CTRL 8'h00
`define EMWB_OFF_STATUS 8'h04
`define EMWB_OFF_EXTRAW 8'h08
`define EMWB_OFF_ERROR 8'h0C
`define EMWB_OFF_ARRIDX 8'h10
`define EMWB_OFF_ARRDATA 8'h14
`define EMWB_OFF_COUNTS 8'h18

// Control register fields and reset value.
`define EMWB_CTRL_WIR_BIT 0
`define EMWB_CTRL_BURST_LSB 4
`define EMWB_CTRL_BURST_MSB 7
`define EMWB_CTRL_RESET 8'h41

// Error register bits.
`define EMWB_ERR_NOT_IDLE 0
`define EMWB_ERR_TOO_SOON 1
`define EMWB_ERR_WIR_OFF 2

// Address bits that carry extended mode fields and the precharge all-banks flag.
`define EMWB_A_DLL 0
`define EMWB_A_DRV_LO 1
`define EMWB_A_DRV_HI 6
`define EMWB_A_ALL_BANKS 10

// Driver strength codes.
`define EMWB_DRV_NORMAL 2'h0
`define EMWB_DRV_WEAK 2'h1
`define EMWB_DRV_MATCHED 2'h2

// Timing counts in link clock cycles.
`define EMWB_EXT_LOAD_CYCLES 2'h2
`define EMWB_MIN_WR_TO_RD 2'h2
`define EMWB_SINCE_SAT 2'h3

`endif

// [emwb_sync.v]
// Two-flop synchroniser for a bus of independent pin levels.
`timescale 1ns/10ps
`default_nettype none
module emwb_sync #(
  parameter W = 8
) (
  // Clock and reset.
  input wire clk,
  input wire resetn,
  // Asynchronous levels in, synchronised levels out.
  input wire [W-1:0] asyncIn,
  output wire [W-1:0] syncOut
);
  reg [W-1:0] stage1Reg; // First stage, read only by the second stage.
  reg [W-1:0] stage2Reg; // Second stage, safe for logic.

  // Both stages take constants under reset; the pins are sampled only when clocked.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stage1Reg <= {W{1'b0}};
      stage2Reg <= {W{1'b0}};
    end else begin
      stage1Reg <= asyncIn;
      stage2Reg <= stage1Reg;
    end
  end

  assign syncOut = stage2Reg;
endmodule // emwb_sync
`default_nettype wire
